// ### include/pbs_pkg.sv
package pbs_pkg;
  // Array geometry
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int BYTE_W = 9; // Eight data bits and one parity bit per lane
  localparam int WORD_W = LANES * BYTE_W;
  localparam int BURST_W = 2;
  // Sleep entry and exit take this many clocks
  localparam int SLEEP_CYC = 2;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  // Synchronous control inputs, all active as named
  typedef struct packed {
    logic procAddrStrobeN;
    logic ctrlAddrStrobeN;
    logic burstAdvanceN;
    logic globalWriteN;
    logic byteWriteEnableN;
    logic [LANES-1:0] byteLaneSelectN;
    logic chipSelectOneN;
    logic chipSelectTwo;
    logic chipSelectThreeN;
  } pbs_ctrl_t;

  // Port-sequencing states
  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_READ = 4'h2,
    ST_WPEND = 4'h4,
    ST_WRITE = 4'h8
  } pbs_state_t;
endpackage

// ### design/pbs_sram_port.sv
`timescale 1ns/10ps
// Functional notes
// [RL1] All synchronous inputs are registered on the rising clock edge.
// [RL2] Read data leaves through output registers, one clock after address capture.
// [RL3] Address is taken only when a strobe is low and all selects active.
// [RL4] Accepted strobe loads address register and low two bits into burst counter.
// [RL5] Wraparound burst counter supplies following addresses from the first one.
// [RL6] Low burst_advance at an edge steps the burst counter.
// [RL7] Strap low gives linear order, high or open gives interleaved.
// [RL8] The far party keeps the burst-order strap static during operation.
// [RL9] With both strobes low only the processor strobe is acted on.
// [RL10] Processor strobe is ignored when chip_select_one_n is high.
// [RL11] Select one and three active low, two active high; all needed.
// [RL12] Chip selects are looked at only when a new address loads.
// [RL13] Low global_write_n writes all four bytes regardless of byte controls.
// [RL14] Byte write needs byte_write_enable_n low; only selected lanes written.
// [RL15] Writes complete internally with no external write pulse timing.
// [RL16] Data and parity lines are captured into a data register each edge.
// [RL17] Lines driven only while output_drive_en_n low; else inputs.
// [RL18] First read clock after deselect keeps the outputs tristated.
// [RL19] High sleep_request enters data-preserving sleep; low in normal use.
// [RL20] Word is 36 bits: four bytes each with its parity bit.
// [RL21] Interleaved order: start offset XOR beat count.
// [RL22] Linear order: start offset plus beat count, modulo four.
// [RL23] Processor-strobe write takes two clocks; controls applied at second edge.
// [RL24] Sleep entry and exit take two clocks; pending accesses may be lost.
// [RL25] Each parity bit is written with its byte under the same qualification.
module pbs_sram_port #(
  parameter int ADDR_W = pbs_pkg::ADDR_W,
  parameter int DEPTH = 1 << pbs_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Synchronous controls and address
  input wire pbs_pkg::pbs_ctrl_t ctrlIn,
  input wire logic [ADDR_W-1:0] addrIn,
  // Static strap and asynchronous controls
  input wire logic burstOrderStrap,
  input wire logic output_drive_en_n,
  input wire logic sleep_request,
  // Data and parity lines, split into in/out/enable
  input wire logic [pbs_pkg::WORD_W-1:0] dataIn,
  output logic [pbs_pkg::WORD_W-1:0] dataOut,
  output logic dataOe,
  // Status
  output logic sleepActive
);
  localparam int LANES = pbs_pkg::LANES;
  localparam int BW = pbs_pkg::BYTE_W;
  localparam int WW = pbs_pkg::WORD_W;

  logic [WW-1:0] memArray [DEPTH];
  pbs_pkg::pbs_ctrl_t ctrl_reg;
  logic [ADDR_W-1:0] addrPin_reg;
  logic [WW-1:0] dataIn_reg;
  logic [ADDR_W-1:0] baseAddr_reg;
  logic [pbs_pkg::BURST_W-1:0] beat_reg;
  logic [pbs_pkg::BURST_W-1:0] beat_next;
  logic interleave_reg;
  logic strapCaught_reg;
  pbs_pkg::pbs_state_t state_reg;
  pbs_pkg::pbs_state_t state_next;
  logic firstRead_reg;
  logic [WW-1:0] rdData_reg;
  logic driveOk_reg;
  logic [1:0] sleepCnt_reg;
  logic sleepIn_reg;

  // Input registers: every synchronous pin is captured first
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= '1;
      addrPin_reg <= '0;
      dataIn_reg <= '0;
      sleepIn_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrlIn; // [RL1]
      addrPin_reg <= addrIn; // [RL1]
      dataIn_reg <= dataIn; // [RL16]
      sleepIn_reg <= sleep_request;
    end
  end

  // Strobe qualification on registered inputs
  wire selAll = !ctrl_reg.chipSelectOneN && ctrl_reg.chipSelectTwo
                && !ctrl_reg.chipSelectThreeN; // [RL11]
  wire procStrobe = !ctrl_reg.procAddrStrobeN && !ctrl_reg.chipSelectOneN; // [RL10]
  // Processor strobe wins when both are low
  wire ctrlStrobe = !ctrl_reg.ctrlAddrStrobeN && !procStrobe; // [RL9]
  wire anyStrobe = procStrobe || ctrlStrobe;
  // Selects only matter on a load edge, so bursts ignore them
  wire loadAddr = anyStrobe && selAll && !sleepActive; // [RL3] [RL12]
  wire deselect = anyStrobe && !selAll;
  wire asleep = sleepActive || sleepIn_reg;
  wire wrGlobal = !ctrl_reg.globalWriteN;
  wire wrByte = !ctrl_reg.byteWriteEnableN;
  wire wrAny = wrGlobal || (wrByte && (ctrl_reg.byteLaneSelectN != '1));
  wire advance = !ctrl_reg.burstAdvanceN && !loadAddr; // [RL6]

  // Burst offset from start and the beat this edge uses
  // An advance edge must already reach the stepped word, or each beat would repeat once
  wire [1:0] startOff = baseAddr_reg[1:0];
  wire [1:0] offInter = startOff ^ beat_next; // [RL21]
  wire [1:0] offLinear = startOff + beat_next; // [RL22]
  wire [1:0] curOff = interleave_reg ? offInter : offLinear; // [RL7]
  wire [ADDR_W-1:0] curAddr = {baseAddr_reg[ADDR_W-1:2], curOff}; // [RL5]
  wire [ADDR_W-1:0] accAddr = loadAddr ? addrPin_reg : curAddr;

  // Lane enables: global write overrides byte controls
  logic [LANES-1:0] laneWr;
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      laneWr[i] = wrGlobal || (wrByte && !ctrl_reg.byteLaneSelectN[i]); // [RL13] [RL14]
    end
  end

  // Write happens when the sequencer says the edge carries a write
  wire writeNow = !asleep && (((state_reg == pbs_pkg::ST_WPEND) && wrAny)
                  || (ctrlStrobe && loadAddr && wrAny)
                  || (!loadAddr && !deselect && (state_reg == pbs_pkg::ST_WRITE) && wrAny));
  wire [ADDR_W-1:0] wrAddr = (state_reg == pbs_pkg::ST_WPEND) ? curAddr : accAddr;

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    if (asleep || deselect)
    begin
      state_next = pbs_pkg::ST_DESEL;
    end
    else if (loadAddr && procStrobe)
    begin
      state_next = pbs_pkg::ST_WPEND; // [RL23] write controls ignored this clock
    end
    else if (loadAddr)
    begin
      state_next = wrAny ? pbs_pkg::ST_WRITE : pbs_pkg::ST_READ;
    end
    else
    begin
      unique case (state_reg)
        pbs_pkg::ST_DESEL: state_next = pbs_pkg::ST_DESEL;
        pbs_pkg::ST_WPEND: state_next = wrAny ? pbs_pkg::ST_WRITE : pbs_pkg::ST_READ; // [RL23]
        pbs_pkg::ST_READ: state_next = wrAny ? pbs_pkg::ST_WRITE : pbs_pkg::ST_READ;
        pbs_pkg::ST_WRITE: state_next = wrAny ? pbs_pkg::ST_WRITE : pbs_pkg::ST_READ;
      endcase
    end
  end

  // Burst beat counter; pending processor write ignores advance
  always_comb
  begin
    beat_next = beat_reg;
    if (loadAddr)
    begin
      beat_next = pbs_pkg::BURST_RST; // [RL4]
    end
    else if (advance && state_reg != pbs_pkg::ST_WPEND && state_reg != pbs_pkg::ST_DESEL)
    begin
      beat_next = beat_reg + 2'h1; // [RL6] wraps after four beats
    end
  end

  // Address, counter and sequencing state
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baseAddr_reg <= '0;
      beat_reg <= pbs_pkg::BURST_RST;
      state_reg <= pbs_pkg::ST_DESEL;
    end
    else
    begin
      if (loadAddr)
      begin
        baseAddr_reg <= addrPin_reg; // [RL4]
      end
      beat_reg <= beat_next;
      state_reg <= state_next;
    end
  end

  // Strap caught once after reset release; it is static afterwards
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strapCaught_reg <= 1'b0;
      interleave_reg <= 1'b1;
    end
    else if (!strapCaught_reg)
    begin
      strapCaught_reg <= 1'b1;
      interleave_reg <= burstOrderStrap; // [RL7] [RL8]
    end
  end

  // Memory array: self-timed write in one edge, parity rides with its byte
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (writeNow && laneWr[i]) // [RL15] [RL25]
      begin
        memArray[wrAddr][i*BW +: BW] <= dataIn_reg[i*BW +: BW]; // [RL20]
      end
    end
  end

  // Read path: output register holds the word of the previous address
  wire readEdge = !asleep && !writeNow && (loadAddr || state_reg == pbs_pkg::ST_READ
                  || state_reg == pbs_pkg::ST_WRITE) && !deselect;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_reg <= '0;
      firstRead_reg <= 1'b0;
      driveOk_reg <= 1'b0;
    end
    else
    begin
      if (readEdge)
      begin
        rdData_reg <= memArray[accAddr]; // [RL2]
      end
      // Mask the first read clock after deselect for depth expansion
      firstRead_reg <= readEdge && (state_reg == pbs_pkg::ST_DESEL); // [RL18]
      driveOk_reg <= readEdge;
    end
  end

  // Output drive: enable is asynchronous, so sample it each edge at this rate
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataOut <= '0;
      dataOe <= 1'b0;
    end
    else
    begin
      dataOut <= readEdge ? memArray[accAddr] : rdData_reg;
      dataOe <= readEdge && !(state_reg == pbs_pkg::ST_DESEL) && !output_drive_en_n; // [RL17] [RL18]
    end
  end

  // Sleep takes two clocks to enter and two to leave
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleepCnt_reg <= pbs_pkg::SLEEP_CNT_RST;
      sleepActive <= 1'b0;
    end
    else if (sleepIn_reg != sleepActive)
    begin
      sleepCnt_reg <= sleepCnt_reg + 2'h1;
      if (sleepCnt_reg == 2'(pbs_pkg::SLEEP_CYC - 1))
      begin
        sleepActive <= sleepIn_reg; // [RL19] [RL24]
        sleepCnt_reg <= pbs_pkg::SLEEP_CNT_RST;
      end
    end
    else
    begin
      sleepCnt_reg <= pbs_pkg::SLEEP_CNT_RST;
    end
  end

  // Checks
  property p_deselOff;
    @(posedge mclk) disable iff (!rst_n) deselect |=> !dataOe;
  endproperty
  a_deselOff: assert property (p_deselOff) else $error("Drive after deselect"); // [RL18]

  property p_driveGate;
    @(posedge mclk) disable iff (!rst_n) output_drive_en_n |=> !dataOe;
  endproperty
  a_driveGate: assert property (p_driveGate) else $error("Drive while enable high"); // [RL17]

  property p_loadBeat;
    @(posedge mclk) disable iff (!rst_n) loadAddr |=> beat_reg == 2'h0;
  endproperty
  a_loadBeat: assert property (p_loadBeat) else $error("Burst not restarted"); // [RL4]

  property p_advStep;
    @(posedge mclk) disable iff (!rst_n)
      (advance && state_reg == pbs_pkg::ST_READ && !asleep && !deselect) |=> beat_reg == $past(beat_reg) + 2'h1;
  endproperty
  a_advStep: assert property (p_advStep) else $error("Burst did not step"); // [RL6]

  property p_noLoadDesel;
    @(posedge mclk) disable iff (!rst_n) (anyStrobe && !selAll) |=> $stable(baseAddr_reg);
  endproperty
  a_noLoadDesel: assert property (p_noLoadDesel) else $error("Address loaded while deselected"); // [RL3]

  property p_procWins;
    @(posedge mclk) disable iff (!rst_n)
      (procStrobe && selAll && !sleepActive && !sleepIn_reg) |=> state_reg == pbs_pkg::ST_WPEND;
  endproperty
  a_procWins: assert property (p_procWins) else $error("Processor strobe not honoured"); // [RL9]

  property p_sleepTwo;
    @(posedge mclk) disable iff (!rst_n) $rose(sleepActive) |-> $past(sleepIn_reg, 2) && $past(sleepIn_reg);
  endproperty
  a_sleepTwo: assert property (p_sleepTwo) else $error("Sleep entered early"); // [RL24]

  property p_wpendNoWrite;
    @(posedge mclk) disable iff (!rst_n) (loadAddr && procStrobe) |-> !writeNow;
  endproperty
  a_wpendNoWrite: assert property (p_wpendNoWrite) else $error("Write on first processor clock"); // [RL23]

  property p_firstMask;
    @(posedge mclk) disable iff (!rst_n) firstRead_reg |-> !dataOe;
  endproperty
  a_firstMask: assert property (p_firstMask) else $error("Drive on first read after deselect"); // [RL18]

  property p_driveRead;
    @(posedge mclk) disable iff (!rst_n) dataOe |-> driveOk_reg;
  endproperty
  a_driveRead: assert property (p_driveRead) else $error("Drive without a read"); // [RL17]

  property p_procIgnored;
    @(posedge mclk) disable iff (!rst_n)
      (!ctrl_reg.procAddrStrobeN && ctrl_reg.chipSelectOneN && ctrl_reg.ctrlAddrStrobeN) |=> $stable(baseAddr_reg);
  endproperty
  a_procIgnored: assert property (p_procIgnored) else $error("Processor strobe taken with select one high"); // [RL10]

  // Dropped selects during a burst must not end it
  property p_burstKeep;
    @(posedge mclk) disable iff (!rst_n)
      (advance && !anyStrobe && !wrAny && !asleep && state_reg == pbs_pkg::ST_READ)
      |=> state_reg == pbs_pkg::ST_READ;
  endproperty
  a_burstKeep: assert property (p_burstKeep) else $error("Burst ended by idle selects"); // [RL12]

  property p_sleepExit;
    @(posedge mclk) disable iff (!rst_n) $fell(sleepActive) |-> !$past(sleepIn_reg, 2) && !$past(sleepIn_reg);
  endproperty
  a_sleepExit: assert property (p_sleepExit) else $error("Sleep left early"); // [RL24]
endmodule

// ### dv/pbs_host_model.sv
`timescale 1ns/10ps
// Cache controller on the far side of the port
module pbs_host_model (
  // Clock
  input wire logic mclk,
  // Controls toward the port
  output pbs_pkg::pbs_ctrl_t ctrlIn,
  output logic [pbs_pkg::ADDR_W-1:0] addrIn,
  output logic burstOrderStrap,
  output logic output_drive_en_n,
  output logic sleep_request,
  // Data lines
  output logic [pbs_pkg::WORD_W-1:0] dataIn,
  input wire logic [pbs_pkg::WORD_W-1:0] dataOut,
  input wire logic dataOe
);
  logic [pbs_pkg::WORD_W-1:0] seenData [$];
  logic seenOe [$];

  // Quiet levels at time zero
  initial
  begin
    ctrlIn = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b1, 1'b0, 1'b1};
    addrIn = '0;
    burstOrderStrap = 1'b1;
    output_drive_en_n = 1'b0;
    sleep_request = 1'b0;
    dataIn = '0;
  end

  // Strap only moves while the port sits in reset
  task automatic set_strap(input logic v);
    burstOrderStrap = v;
  endtask

  // One cycle: drive after an edge, hold through the next edge, then record
  task automatic step(input pbs_pkg::pbs_ctrl_t c, input logic [pbs_pkg::ADDR_W-1:0] a,
      input logic [pbs_pkg::WORD_W-1:0] d);
    ctrlIn = c;
    addrIn = a;
    // Released lines toggle, so a stale word never passes for read data
    dataIn = (!c.globalWriteN || !c.byteWriteEnableN) ? d : ~dataIn;
    @(posedge mclk);
    #1;
    seenData.push_back(dataOut);
    seenOe.push_back(dataOe);
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the burst port
module testbench;
  localparam int LAT = 1;
  localparam logic [16:0] BASE = 17'h10100;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  pbs_pkg::pbs_ctrl_t ctrlIn;
  logic [16:0] addrIn;
  logic burstOrderStrap, output_drive_en_n, sleep_request, dataOe, sleepActive;
  logic [35:0] dataIn, dataOut;
  logic [35:0] mem [4];
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 mclk = ~mclk;

  pbs_host_model host (.mclk(mclk), .ctrlIn(ctrlIn), .addrIn(addrIn), .burstOrderStrap(burstOrderStrap),
    .output_drive_en_n(output_drive_en_n), .sleep_request(sleep_request), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe));
  pbs_sram_port dut (.mclk(mclk), .rst_n(rst_n), .ctrlIn(ctrlIn), .addrIn(addrIn),
    .burstOrderStrap(burstOrderStrap), .output_drive_en_n(output_drive_en_n),
    .sleep_request(sleep_request), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .sleepActive(sleepActive));

  function automatic pbs_pkg::pbs_ctrl_t mk(input logic ps, cs, burst_advance, gw, byte_write_enable_n, input logic [3:0] ln,
      input logic sel);
    return '{ps, cs, burst_advance, gw, byte_write_enable_n, ln, ~sel, 1'b1, 1'b0};
  endfunction
  // Idle, deselect, controller read and write, advance with selects dropped
  localparam pbs_pkg::pbs_ctrl_t IDLE = mk(1, 1, 1, 1, 1, 4'hf, 1);
  localparam pbs_pkg::pbs_ctrl_t DESEL = mk(1, 0, 1, 1, 1, 4'hf, 0);
  localparam pbs_pkg::pbs_ctrl_t CRD = mk(1, 0, 1, 1, 1, 4'hf, 1);
  localparam pbs_pkg::pbs_ctrl_t CWR = mk(1, 0, 1, 0, 1, 4'hf, 1);
  localparam pbs_pkg::pbs_ctrl_t BURST_ADVANCE = mk(1, 1, 0, 1, 1, 4'hf, 0);

  function automatic logic [35:0] pat(input int i);
    return 36'h3c5a69f12 ^ {4{i[8:0]}};
  endfunction

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Hang guard, far past the hundred or so cycles needed
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      give_verdict();
    end
  end

  task automatic do_reset(input logic strap);
    rst_n = 1'b0;
    host.set_strap(strap);
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    host.seenData.delete();
    host.seenOe.delete();
  endtask

  // Global writes, then back-to-back reads straight after a deselect
  task automatic t_write_read();
    for (int i = 0; i < 4; i++)
    begin
      mem[i] = pat(i);
      host.step(CWR, 17'(BASE + i), mem[i]);
    end
    host.step(DESEL, '0, '0);
    for (int i = 0; i < 4; i++)
      host.step(CRD, 17'(BASE + i), '0);
    repeat (2) host.step(IDLE, '0, '0);
    for (int i = 0; i < 4; i++)
    begin
      chk_word("read word", mem[i], host.seenData[5 + i + LAT]);
      chk_bit("read drive", i > 0, host.seenOe[5 + i + LAT]);
    end
  endtask

  // Processor write with early write controls, then both strobes at once
  task automatic t_byte_write();
    logic [35:0] w;
    int n;
    w = pat(11);
    n = host.seenData.size();
    host.step(mk(0, 1, 1, 0, 1, 4'h0, 1), 17'(BASE + 1), pat(10));
    host.step(mk(1, 1, 1, 1, 0, 4'ha, 1), '0, w);
    mem[1][8:0] = w[8:0];
    mem[1][26:18] = w[26:18];
    host.step(mk(0, 0, 1, 0, 1, 4'hf, 1), 17'(BASE + 2), pat(12));
    host.step(IDLE, '0, '0);
    host.step(DESEL, '0, '0);
    host.step(CRD, 17'(BASE + 1), '0);
    host.step(CRD, 17'(BASE + 2), '0);
    repeat (2) host.step(IDLE, '0, '0);
    chk_word("lane write", mem[1], host.seenData[n + 5 + LAT]);
    chk_word("strobe priority", mem[2], host.seenData[n + 6 + LAT]);
  endtask

  // Four-beat burst; offset order packed two bits a beat
  task automatic t_burst(input logic [1:0] first, input logic [7:0] order);
    int n;
    n = host.seenData.size();
    host.step(DESEL, '0, '0);
    host.step(CRD, BASE | 17'(first), '0);
    repeat (3) host.step(BURST_ADVANCE, '0, '0);
    repeat (2) host.step(IDLE, '0, '0);
    for (int k = 0; k < 4; k++)
      chk_word("burst word", mem[order[2*k +: 2]], host.seenData[n + 1 + k + LAT]);
  endtask

  // Ignored strobe, select three off, and outputs held off
  task automatic t_refuse();
    pbs_pkg::pbs_ctrl_t c;
    int n;
    c = CRD;
    c.chipSelectThreeN = 1'b1;
    n = host.seenOe.size();
    host.step(DESEL, '0, '0);
    host.step(CRD, BASE, '0);
    host.step(CRD, BASE, '0);
    host.step(mk(0, 1, 1, 1, 1, 4'hf, 0), 17'(BASE + 3), '0);
    host.step(c, BASE, '0);
    host.step(IDLE, '0, '0);
    chk_bit("first read", 1'b0, host.seenOe[n + 1 + LAT]);
    chk_bit("second read", 1'b1, host.seenOe[n + 2 + LAT]);
    chk_bit("ignored strobe", 1'b1, host.seenOe[n + 3 + LAT]);
    chk_word("ignored strobe word", mem[0], host.seenData[n + 3 + LAT]);
    chk_bit("select three off", 1'b0, host.seenOe[n + 4 + LAT]);
    host.output_drive_en_n = 1'b1;
    host.step(DESEL, '0, '0);
    repeat (2) host.step(CRD, BASE, '0);
    host.step(IDLE, '0, '0);
    chk_bit("drive disabled", 1'b0, host.seenOe[n + 8 + LAT]);
    host.output_drive_en_n = 1'b0;
  endtask

  task automatic t_sleep();
    host.sleep_request = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk_bit("sleep entry early", 1'b0, sleepActive);
    @(posedge mclk);
    #1;
    chk_bit("asleep", 1'b1, sleepActive);
    host.sleep_request = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk_bit("sleep exit early", 1'b1, sleepActive);
    @(posedge mclk);
    #1;
    chk_bit("awake", 1'b0, sleepActive);
    t_burst(2'h1, 8'h39);
  endtask

  initial
  begin
    do_reset(1'b0);
    t_write_read();
    t_byte_write();
    t_burst(2'h1, 8'h39);
    t_refuse();
    t_sleep();
    do_reset(1'b1);
    t_burst(2'h1, 8'hb1);
    t_burst(2'h2, 8'h4e);
    give_verdict();
  end
endmodule
